// ---- core/tsmc_pkg.sv ----
// package: register map, field positions and mode codes of the slave block
// How it works
// [RULE_01] ctrl2 bit 11 sets channel 2 complementary idle
// [RULE_02] ctrl2 bit 12 sets channel 3 main idle
// [RULE_03] ctrl2 bit 13 sets channel 3 complementary idle
// [RULE_04] ctrl2 bit 14 sets channel 4 idle; 15 reserved
// [RULE_05] mode 000: count on internal clock when enabled
// [RULE_06] mode 001: count ch2 edges, ch1 sets direction
// [RULE_07] mode 010: count ch1 edges, ch2 sets direction
// [RULE_08] mode 011: count both edges, other sets direction
// [RULE_09] mode 100: trigger rise clears counter, pulses update
// [RULE_10] mode 101: count while trigger high, never reset
// [RULE_11] mode 110: trigger rise starts the counter
// [RULE_12] mode 111: trigger rising edges clock the counter
// [RULE_13] smc bit 3 picks compare reference clear source
// [RULE_14] slave register at 0x08, resets to zero
// [RULE_15] idle levels apply only while main output disabled
// [RULE_16] idle bits locked at protection level 1-3
// [RULE_17] trigger select changed only with mode 000
// [RULE_18] reserved bits read zero, writes ignored
package tsmc_pkg;
    // bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;
    // register byte offsets
    localparam logic [7:0] CTRL1_OFF = 8'h00;
    localparam logic [7:0] CTRL2_OFF = 8'h04;
    localparam logic [7:0] SMC_OFF   = 8'h08;
    localparam logic [7:0] CNT_OFF   = 8'h24;
    localparam logic [7:0] GUARD_OFF = 8'h44;
    // reset values
    localparam logic [15:0] CTRL2_RST = 16'h0000;
    localparam logic [15:0] SMC_RST   = 16'h0000;
    localparam logic [15:0] GUARD_RST = 16'h0000;
    // control 1 fields
    localparam int CNTEN_BIT = 0;
    localparam int DIR_BIT   = 4;
    // control 2 idle-level fields, bits 8 to 14
    localparam int CH1_MAIN_BIT = 8;
    localparam int CH1_COMP_BIT = 9;
    localparam int CH2_MAIN_BIT = 10;
    localparam int CH2_COMP_BIT = 11;
    localparam int CH3_MAIN_BIT = 12;
    localparam int CH3_COMP_BIT = 13;
    localparam int CH4_MAIN_BIT = 14;
    localparam int IDLE_W       = 7;
    localparam logic [15:0] CTRL2_WMASK = 16'h7f00;
    // slave mode control fields
    localparam int SMF_LO     = 0;
    localparam int CLRSEL_BIT = 3;
    localparam logic [15:0] SMC_WMASK = 16'h000f;
    // guard register fields
    localparam int PROT_LO = 0;
    localparam int MOE_BIT = 2;
    localparam logic [15:0] GUARD_WMASK = 16'h0007;
    // slave function codes
    localparam logic [2:0] MODE_OFF  = 3'h0;
    localparam logic [2:0] MODE_ENC1 = 3'h1;
    localparam logic [2:0] MODE_ENC2 = 3'h2;
    localparam logic [2:0] MODE_ENC3 = 3'h3;
    localparam logic [2:0] MODE_RST  = 3'h4;
    localparam logic [2:0] MODE_GATE = 3'h5;
    localparam logic [2:0] MODE_TRIG = 3'h6;
    localparam logic [2:0] MODE_EXT  = 3'h7;
    // pin input indices
    localparam int IN_CH1 = 0;
    localparam int IN_CH2 = 1;
    localparam int IN_TRG = 2;
    localparam int IN_CLR = 3;
    localparam int IN_ETR = 4;
    localparam int IN_N   = 5;
endpackage : tsmc_pkg

// ---- core/tsmc_sync_edge.sv ----
// two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module tsmc_sync_edge (
    input  wire logic clk_i,   // timer clock
    input  wire logic rst_i,   // synchronous reset
    input  wire logic d_i,     // asynchronous pin
    output logic      level_o, // synchronised level
    output logic      rise_o,  // one-cycle rise pulse
    output logic      fall_o   // one-cycle fall pulse
);
    logic meta_reg, meta_next;   // first stage, read only by sync
    logic sync_reg, sync_next;   // second stage
    logic last_reg, last_next;   // previous synced value

    // next values of the shift chain
    always_comb begin
        meta_next = d_i;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    // chain registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    // edges come from the two settled stages only
    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule : tsmc_sync_edge

// ---- core/tsmc_core.sv ----
// timer slave-mode controller, idle levels and wishbone registers
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module tsmc_core #(
    parameter int               CNT_W  = 16,  // counter width
    parameter logic [CNT_W-1:0] RELOAD = '1   // wrap value
) (
    input  wire logic             clk_i,          // timer clock
    input  wire logic             rst_i,          // sync reset
    input  wire logic             wb_cyc_i,       // bus cycle
    input  wire logic             wb_stb_i,       // bus strobe
    input  wire logic             wb_we_i,        // write
    input  wire logic [7:0]       wb_adr_i,       // byte address
    input  wire logic [3:0]       wb_sel_i,       // byte lanes
    input  wire logic [31:0]      wb_dat_i,       // write data
    output logic      [31:0]      wb_dat_o,       // read data
    output logic                  wb_ack_o,       // acknowledge
    input  wire logic             filtered_ch1_input_i,
    input  wire logic             filtered_ch2_input_i,
    input  wire logic             trigger_input_i,
    input  wire logic             compare_ref_clear_input_i,
    input  wire logic             filtered_external_trigger_i,
    output logic      [CNT_W-1:0] counter_o,      // counter value
    output logic                  count_down_o,   // direction
    output logic                  update_o,       // update event
    output logic                  compare_ref_clear_o, // clear level
    output logic                  idle_force_o,   // idle in force
    output logic      [6:0]       idle_levels_o   // ch1..ch4 idle
);
    // pins gathered for the synchroniser loop
    logic [tsmc_pkg::IN_N-1:0] pin_raw;
    logic [tsmc_pkg::IN_N-1:0] pin_lvl;   // settled levels
    logic [tsmc_pkg::IN_N-1:0] pin_rise;  // rising pulses
    logic [tsmc_pkg::IN_N-1:0] pin_fall;  // falling pulses

    assign pin_raw = {filtered_external_trigger_i,
                      compare_ref_clear_input_i,
                      trigger_input_i,
                      filtered_ch2_input_i,
                      filtered_ch1_input_i};

    // every pin crosses two flops before any logic sees it
    genvar gi;
    generate
        for (gi = 0; gi < tsmc_pkg::IN_N; gi++) begin : g_sync
            tsmc_sync_edge u_sync (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .d_i     (pin_raw[gi]),
                .level_o (pin_lvl[gi]),
                .rise_o  (pin_rise[gi]),
                .fall_o  (pin_fall[gi])
            );
        end
    endgenerate

    // short names for the settled pins
    logic ch1_lvl, ch2_lvl, trg_lvl, trg_rise;
    logic ch1_rise, ch1_fall, ch2_rise, ch2_fall;
    assign ch1_lvl  = pin_lvl[tsmc_pkg::IN_CH1];
    assign ch2_lvl  = pin_lvl[tsmc_pkg::IN_CH2];
    assign trg_lvl  = pin_lvl[tsmc_pkg::IN_TRG];
    assign trg_rise = pin_rise[tsmc_pkg::IN_TRG];
    assign ch1_rise = pin_rise[tsmc_pkg::IN_CH1];
    assign ch1_fall = pin_fall[tsmc_pkg::IN_CH1];
    assign ch2_rise = pin_rise[tsmc_pkg::IN_CH2];
    assign ch2_fall = pin_fall[tsmc_pkg::IN_CH2];

    // word decode, used by reads and writes alike
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction : hit

    // byte-lane merge limited to the writable bits
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  sel,
                                          input logic [15:0] mask);
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        return (old & ~lane) | (wd & lane);
    endfunction : merge

    // ---------------- bus slave ----------------
    logic        ack_reg, ack_next;     // one-cycle answer
    logic [31:0] dat_reg, dat_next;     // read data
    logic        req;                   // request present
    logic        wr_go;                 // write lands this edge
    logic [15:0] wd16;                  // low half of write data
    logic [31:0] rd_val;                // read mux result

    // registers software sees
    logic             cnten_reg, cnten_next;   // counter_enable_bit
    logic [15:0]      ctrl2_reg, ctrl2_next;   // idle levels
    logic [15:0]      smc_reg, smc_next;       // slave_mode_control
    logic [15:0]      guard_reg, guard_next;   // protection and moe
    logic [2:0]       mode;                    // slave_function_select
    logic             clr_src;                 // compare_ref_clear_source
    logic [1:0]       prot;                    // protection_level
    logic             moe;                     // main_output_enable

    assign mode    = smc_reg[tsmc_pkg::SMF_LO +: 3];
    assign clr_src = smc_reg[tsmc_pkg::CLRSEL_BIT];
    assign prot    = guard_reg[tsmc_pkg::PROT_LO +: 2];
    assign moe     = guard_reg[tsmc_pkg::MOE_BIT];
    assign req     = wb_cyc_i & wb_stb_i;
    assign wd16    = wb_dat_i[15:0];

    // counter state
    logic [CNT_W-1:0] cnt_reg, cnt_next;   // counter
    logic             dir_reg, dir_next;   // 1 while counting down
    logic             upd_reg, upd_next;   // update pulse

    // read mux; unmapped words read as zero
    always_comb begin
        rd_val = 32'h0;
        if (hit(wb_adr_i, tsmc_pkg::CTRL1_OFF)) begin
            rd_val[tsmc_pkg::CNTEN_BIT] = cnten_reg;
            rd_val[tsmc_pkg::DIR_BIT]   = dir_reg;
        end else if (hit(wb_adr_i, tsmc_pkg::CTRL2_OFF)) begin
            rd_val[15:0] = ctrl2_reg; // reserved bits stay zero
        end else if (hit(wb_adr_i, tsmc_pkg::SMC_OFF)) begin
            rd_val[15:0] = smc_reg;
        end else if (hit(wb_adr_i, tsmc_pkg::CNT_OFF)) begin
            rd_val[CNT_W-1:0] = cnt_reg;
        end else if (hit(wb_adr_i, tsmc_pkg::GUARD_OFF)) begin
            rd_val[15:0] = guard_reg;
        end
    end

    // answer one cycle after the request; write lands with the ack
    always_comb begin
        ack_next = req & ~ack_reg;
        dat_next = ack_next ? rd_val : 32'h0;
        wr_go    = req & wb_we_i & ack_reg;
    end

    // bus registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // ---------------- control registers ----------------
    // writes obey masks so reserved bits never store anything
    always_comb begin
        ctrl2_next = ctrl2_reg;
        smc_next   = smc_reg;
        guard_next = guard_reg;
        cnten_next = cnten_reg;
        if (wr_go && hit(wb_adr_i, tsmc_pkg::CTRL1_OFF)
            && wb_sel_i[0]) begin
            cnten_next = wd16[tsmc_pkg::CNTEN_BIT];
        end
        // idle bits frozen once any protection level is set
        if (wr_go && hit(wb_adr_i, tsmc_pkg::CTRL2_OFF)
            && prot == 2'h0) begin // [RULE_16]
            ctrl2_next = merge(ctrl2_reg, wd16, wb_sel_i[1:0],
                               tsmc_pkg::CTRL2_WMASK); // [RULE_18]
        end
        // software keeps trigger source changes to mode 000
        if (wr_go && hit(wb_adr_i, tsmc_pkg::SMC_OFF)) begin
            smc_next = merge(smc_reg, wd16, wb_sel_i[1:0],
                             tsmc_pkg::SMC_WMASK); // [RULE_18]
        end
        if (wr_go && hit(wb_adr_i, tsmc_pkg::GUARD_OFF)) begin
            guard_next = merge(guard_reg, wd16, wb_sel_i[1:0],
                               tsmc_pkg::GUARD_WMASK);
        end
        // trigger start wins over a clearing write
        if (mode == tsmc_pkg::MODE_TRIG && trg_rise) begin
            cnten_next = 1'b1; // [RULE_11]
        end
    end

    // control registers, all zero after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnten_reg <= 1'b0;
            ctrl2_reg <= tsmc_pkg::CTRL2_RST;
            smc_reg   <= tsmc_pkg::SMC_RST; // [RULE_14]
            guard_reg <= tsmc_pkg::GUARD_RST;
        end else begin
            cnten_reg <= cnten_next;
            ctrl2_reg <= ctrl2_next;
            smc_reg   <= smc_next;
            guard_reg <= guard_next;
        end
    end

    // ---------------- counter ----------------
    logic step_up, step_dn, clr_cnt;   // this cycle's action

    // choose what moves the counter for each slave function
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        clr_cnt = 1'b0;
        case (mode)
            tsmc_pkg::MODE_OFF: begin
                step_up = cnten_reg; // [RULE_05]
            end
            tsmc_pkg::MODE_ENC1: begin
                // ch2 edges counted, ch1 level steers
                step_up = cnten_reg & ((ch2_rise & ch1_lvl)
                          | (ch2_fall & ~ch1_lvl)); // [RULE_06]
                step_dn = cnten_reg & ((ch2_rise & ~ch1_lvl)
                          | (ch2_fall & ch1_lvl)); // [RULE_06]
            end
            tsmc_pkg::MODE_ENC2: begin
                // ch1 edges counted, ch2 level steers
                step_up = cnten_reg & ((ch1_rise & ~ch2_lvl)
                          | (ch1_fall & ch2_lvl)); // [RULE_07]
                step_dn = cnten_reg & ((ch1_rise & ch2_lvl)
                          | (ch1_fall & ~ch2_lvl)); // [RULE_07]
            end
            tsmc_pkg::MODE_ENC3: begin
                // opposing edges in one cycle cancel out
                step_up = cnten_reg & ((ch2_rise & ch1_lvl)
                          | (ch2_fall & ~ch1_lvl)
                          | (ch1_rise & ~ch2_lvl)
                          | (ch1_fall & ch2_lvl)); // [RULE_08]
                step_dn = cnten_reg & ((ch2_rise & ~ch1_lvl)
                          | (ch2_fall & ch1_lvl)
                          | (ch1_rise & ch2_lvl)
                          | (ch1_fall & ~ch2_lvl)); // [RULE_08]
            end
            tsmc_pkg::MODE_RST: begin
                step_up = cnten_reg;
                clr_cnt = trg_rise; // [RULE_09]
            end
            tsmc_pkg::MODE_GATE: begin
                step_up = cnten_reg & trg_lvl; // [RULE_10]
            end
            tsmc_pkg::MODE_TRIG: begin
                step_up = cnten_reg; // [RULE_11]
            end
            tsmc_pkg::MODE_EXT: begin
                step_up = cnten_reg & trg_rise; // [RULE_12]
            end
            default: begin
                step_up = 1'b0;
            end
        endcase
    end

    // counter next value; wrap also raises an update
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        upd_next = 1'b0;
        if (clr_cnt) begin
            cnt_next = '0; // [RULE_09]
            upd_next = 1'b1; // [RULE_09]
        end else if (step_up && !step_dn) begin
            dir_next = 1'b0;
            if (cnt_reg == RELOAD) begin
                cnt_next = '0;
                upd_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else if (step_dn && !step_up) begin
            dir_next = 1'b1;
            if (cnt_reg == '0) begin
                cnt_next = RELOAD;
                upd_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    // counter registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            dir_reg <= 1'b0;
            upd_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            upd_reg <= upd_next;
        end
    end

    // ---------------- output levels ----------------
    logic       clrout_reg, clrout_next;   // selected clear level
    logic       force_reg, force_next;     // idle levels in force
    logic [6:0] idle_reg, idle_next;       // idle levels driven

    // idle bits reach the pins only while outputs are disabled
    always_comb begin
        clrout_next = clr_src ? pin_lvl[tsmc_pkg::IN_ETR]
                              : pin_lvl[tsmc_pkg::IN_CLR]; // [RULE_13]
        force_next  = ~moe; // [RULE_15]
        idle_next   = 7'h00;
        if (!moe) begin
            idle_next = ctrl2_reg[tsmc_pkg::CH1_MAIN_BIT
                                  +: tsmc_pkg::IDLE_W]; // [RULE_15]
            idle_next[tsmc_pkg::CH2_COMP_BIT - tsmc_pkg::CH1_MAIN_BIT]
                = ctrl2_reg[tsmc_pkg::CH2_COMP_BIT]; // [RULE_01]
            idle_next[tsmc_pkg::CH3_MAIN_BIT - tsmc_pkg::CH1_MAIN_BIT]
                = ctrl2_reg[tsmc_pkg::CH3_MAIN_BIT]; // [RULE_02]
            idle_next[tsmc_pkg::CH3_COMP_BIT - tsmc_pkg::CH1_MAIN_BIT]
                = ctrl2_reg[tsmc_pkg::CH3_COMP_BIT]; // [RULE_03]
            idle_next[tsmc_pkg::CH4_MAIN_BIT - tsmc_pkg::CH1_MAIN_BIT]
                = ctrl2_reg[tsmc_pkg::CH4_MAIN_BIT]; // [RULE_04]
        end
    end

    // output registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clrout_reg <= 1'b0;
            force_reg  <= 1'b0;
            idle_reg   <= 7'h00;
        end else begin
            clrout_reg <= clrout_next;
            force_reg  <= force_next;
            idle_reg   <= idle_next;
        end
    end

    // every output straight from a flop
    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = dat_reg;
    assign counter_o           = cnt_reg;
    assign count_down_o        = dir_reg;
    assign update_o            = upd_reg;
    assign compare_ref_clear_o = clrout_reg;
    assign idle_force_o        = force_reg;
    assign idle_levels_o       = idle_reg;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a write to control 2 that the bus completes
    sequence s_ctrl2_wr;
        wr_go && hit(wb_adr_i, tsmc_pkg::CTRL2_OFF);
    endsequence

    // a trigger edge seen in reset mode
    sequence s_rst_edge;
        mode == tsmc_pkg::MODE_RST && trg_rise;
    endsequence

    a_ack_single: assert property (
        ack_reg |=> !ack_reg)
        else $error("ack held longer than one cycle");

    a_reset_clear: assert property ( // [RULE_09]
        s_rst_edge |=> cnt_reg == '0 && upd_reg)
        else $error("reset mode edge did not clear the counter");

    a_gate_hold: assert property ( // [RULE_10]
        mode == tsmc_pkg::MODE_GATE && !trg_lvl
        |=> $stable(cnt_reg))
        else $error("gated counter moved while trigger low");

    a_trig_start: assert property ( // [RULE_11]
        mode == tsmc_pkg::MODE_TRIG && trg_rise |=> cnten_reg)
        else $error("trigger edge did not start the counter");

    a_ext_step: assert property ( // [RULE_12]
        mode == tsmc_pkg::MODE_EXT && cnten_reg && !trg_rise
        |=> $stable(cnt_reg))
        else $error("external clock mode moved without an edge");

    a_free_run: assert property ( // [RULE_05]
        mode == tsmc_pkg::MODE_OFF && cnten_reg && cnt_reg != RELOAD
        |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("free run did not advance by one");

    a_enc1_up: assert property ( // [RULE_06]
        mode == tsmc_pkg::MODE_ENC1 && cnten_reg && ch2_rise
        && ch1_lvl && cnt_reg != RELOAD
        |=> cnt_reg == $past(cnt_reg) + 1'b1 && !dir_reg)
        else $error("encoder mode 1 did not count up");

    a_idle_lock: assert property ( // [RULE_16]
        s_ctrl2_wr and (prot != 2'h0) |=> $stable(ctrl2_reg))
        else $error("idle bits changed while locked");

    a_idle_gate: assert property ( // [RULE_15]
        moe |=> idle_reg == 7'h00 && !force_reg)
        else $error("idle levels driven with outputs enabled");

    a_clr_select: assert property ( // [RULE_13]
        clr_src ##1 clr_src |-> clrout_reg
        == $past(pin_lvl[tsmc_pkg::IN_ETR]))
        else $error("clear output not following external trigger");

    a_smc_reserved: assert property ( // [RULE_18]
        smc_reg[15:4] == 12'h000)
        else $error("reserved slave mode bits became set");
endmodule : tsmc_core

// ---- verif/tsmc_enc_model.sv ----
// quadrature encoder model driving the two filtered channel lines
`timescale 1ns/1ps
module tsmc_enc_model (
    input  wire logic clk_i,  // timer clock
    input  wire logic step_i, // advance one phase
    input  wire logic back_i, // step backwards
    output logic      ch1_o,  // phase a
    output logic      ch2_o   // phase b
);
    logic [1:0] ph_reg = 2'h0; // phase count
    // gray order: one line moves per step, so no false double edge
    always @(posedge clk_i) begin
        if (step_i) ph_reg <= back_i ? ph_reg - 2'h1 : ph_reg + 2'h1;
    end
    assign ch1_o = ph_reg[1] ^ ph_reg[0];
    assign ch2_o = ph_reg[1];
endmodule : tsmc_enc_model

// ---- verif/tsmc_core_test.sv ----
// register and slave-mode tests of the timer slave block
`timescale 1ns/1ps
module tsmc_core_test;
    logic        clk_i = 1'b0; // timer clock
    logic        rst_i = 1'b1; // sync reset
    logic        req   = 1'b0; // cyc and stb together
    logic        we    = 1'b0; // write
    logic [7:0]  adr   = 8'h00; // address
    logic [31:0] wdat  = 32'h0; // write data
    logic [31:0] rdat, q; // read data, last taken
    logic        stp = 1'b0, bck = 1'b0, ch1, ch2; // encoder
    logic        trg = 1'b0, clr = 1'b0, etr = 1'b0; // pins
    logic [15:0] cnt, c0, df, ad; // counter views, ad is the size of the count moved by one encoder pass
    int          ex; // steps expected from one encoder pass
    logic        dn, cdn, upd, ack, cro, idf;
    logic [6:0]  idl; // idle levels
    int          miscompares = 0;
    int          checks_done = 0;

    always #4 clk_i = ~clk_i;

    tsmc_core i_tsmc_core (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .filtered_ch1_input_i(ch1), .filtered_ch2_input_i(ch2),
        .trigger_input_i(trg), .compare_ref_clear_input_i(clr),
        .filtered_external_trigger_i(etr), .counter_o(cnt),
        .count_down_o(cdn), .update_o(upd), .compare_ref_clear_o(cro),
        .idle_force_o(idf), .idle_levels_o(idl));
    tsmc_enc_model i_tsmc_enc_model (.clk_i(clk_i), .step_i(stp),
        .back_i(bck), .ch1_o(ch1), .ch2_o(ch2));

    task automatic stop_test;
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    // counter compare, the common case
    task automatic chc(input string nm, input logic [15:0] e);
        chk(nm, {16'h0, e}, {16'h0, cnt});
    endtask : chc

    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk

    // one classic cycle; bounded wait so a dead slave cannot hang us
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        req <= 1'b0;
        if (ack !== 1'b1) begin
            chk("ack", 32'h1, {31'h0, ack});
            stop_test();
        end
        @(posedge clk_i);
    endtask : wb

    // four encoder steps, spaced so the synchroniser sees each edge
    task automatic enc(input logic b);
        repeat (4) begin
            stp <= 1'b1;
            bck <= b;
            @(posedge clk_i);
            stp <= 1'b0;
            tk(4);
        end
        tk(6);
    endtask : enc

    task automatic stepchk(input string nm);
        c0 = cnt;
        tk(1);
        chc(nm, c0 + 16'h1);
    endtask : stepchk

    initial begin
        tk(16);
        rst_i <= 1'b0;
        tk(1);
        wb(0, tsmc_pkg::SMC_OFF, 0);
        chk("smc reset", 32'h0, q);
        wb(0, 8'h30, 0);
        chk("unmapped", 32'h0, q);
        wb(1, tsmc_pkg::SMC_OFF, 32'hffff);
        wb(0, tsmc_pkg::SMC_OFF, 0);
        chk("smc mask", 32'h000f, q);
        for (int i = 0; i < 7; i++) begin
            wb(1, tsmc_pkg::CTRL2_OFF, 32'h100 << i);
            tk(4);
            chk("idl", 1<<i, idl);
        end
        wb(1, tsmc_pkg::CTRL2_OFF, 32'hffff);
        wb(0, tsmc_pkg::CTRL2_OFF, 0);
        chk("ctrl2 mask", 32'h7f00, q);
        wb(1, tsmc_pkg::GUARD_OFF, 32'h4);
        tk(4);
        chk("idle off", 32'h0, {24'h0, idf, idl});
        wb(1, tsmc_pkg::GUARD_OFF, 32'h1);
        wb(1, tsmc_pkg::CTRL2_OFF, 32'h0);
        wb(0, tsmc_pkg::CTRL2_OFF, 0);
        chk("locked", 32'h7f00, q);
        chk("idle on", 32'hff, {24'h0, idf, idl});
        // the mask test left external clock mode on; back to 000 first
        wb(1, tsmc_pkg::SMC_OFF, 0);
        wb(1, tsmc_pkg::CTRL1_OFF, 1);
        tk(4);
        stepchk("free run");
        for (int m = 1; m < 4; m++) begin
            wb(1, tsmc_pkg::CTRL1_OFF, 0);
            wb(1, tsmc_pkg::SMC_OFF, m);
            wb(1, tsmc_pkg::CTRL1_OFF, 1);
            ex = (m == 3) ? 4 : 2;
            c0 = cnt;
            enc(1'b0);
            df = cnt - c0;
            dn = cdn;
            ad = df[15] ? 16'h0 - df : df;
            chk("enc fwd", ex, ad);
            c0 = cnt;
            enc(1'b1);
            chc("enc back", c0 - df);
            chk("enc dir", !dn, cdn);
        end
        wb(1, tsmc_pkg::SMC_OFF, 5);
        tk(4);
        c0 = cnt;
        tk(5);
        chc("gate low", c0);
        trg <= 1'b1;
        tk(6);
        stepchk("gate high");
        trg <= 1'b0;
        tk(6);
        c0 = cnt;
        tk(5);
        chc("gate hold", c0);
        chk("gate kept", 32'h1, {31'h0, c0 != 16'h0});
        wb(1, tsmc_pkg::CTRL1_OFF, 0);
        wb(1, tsmc_pkg::SMC_OFF, 6);
        c0 = cnt;
        tk(4);
        chc("trig idle", c0);
        trg <= 1'b1;
        tk(8);
        stepchk("trig run");
        wb(0, tsmc_pkg::CTRL1_OFF, 0);
        chk("trig en", 32'h1, q & 32'h1);
        trg <= 1'b0;
        wb(1, tsmc_pkg::SMC_OFF, 7);
        c0 = cnt;
        repeat (3) begin
            trg <= 1'b1;
            tk(4);
            trg <= 1'b0;
            tk(4);
        end
        tk(4);
        chc("ext clock", c0 + 16'h3);
        wb(1, tsmc_pkg::SMC_OFF, 4);
        trg <= 1'b1;
        for (int n = 0; n < 10 && upd !== 1'b1; n++) @(posedge clk_i);
        chk("rst update", 32'h1, {31'h0, upd});
        chc("rst count", 16'h0);
        trg <= 1'b0;
        wb(1, tsmc_pkg::SMC_OFF, 0);
        clr <= 1'b1;
        tk(5);
        chk("clr pin", 32'h1, {31'h0, cro});
        wb(1, tsmc_pkg::SMC_OFF, 8);
        tk(4);
        chk("clr etr lo", 32'h0, {31'h0, cro});
        etr <= 1'b1;
        tk(5);
        chk("clr etr hi", 32'h1, {31'h0, cro});
        stop_test();
    end
endmodule : tsmc_core_test
